// File: design/bawd_top.sv
// address window decode for both crossing directions
module bawd_top import bawd_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic memory_space_enable_i,
	input wire logic io_space_enable_i,
	input wire logic bus_master_enable_i,
	input wire logic isa_enable_i,
	input wire logic vga_enable_i,
	input wire logic vga_16bit_enable_i,
	input wire logic upstream_prefetchable_i,
	input wire logic [BAWD_MEM_W-1:0] mem_base_i,
	input wire logic [BAWD_MEM_W-1:0] mem_limit_i,
	input wire logic [BAWD_PF_W-1:0] pf_base_i,
	input wire logic [BAWD_PF_W-1:0] pf_limit_i,
	input wire logic [BAWD_IO_W-1:0] io_base_i,
	input wire logic [BAWD_IO_W-1:0] io_limit_i,
	input wire logic dn_req_valid_i,
	input wire logic dn_req_is_io_i,
	input wire logic dn_req_is_64_i,
	input wire logic dn_req_is_read_i,
	input wire logic [BAWD_ADDR_W-1:0] dn_req_addr_i,
	input wire logic [BAWD_BCNT_W-1:0] dn_req_byte_count_i,
	input wire logic up_req_valid_i,
	input wire logic up_req_is_io_i,
	input wire logic up_req_is_64_i,
	input wire logic [3:0] up_req_cmd_i,
	input wire logic [BAWD_ADDR_W-1:0] up_req_addr_i,
	output logic dn_rsp_valid_o,
	output logic dn_fwd_o,
	output logic dn_ur_o,
	output logic [BAWD_BCNT_W-1:0] dn_read_bytes_o,
	output logic up_rsp_valid_o,
	output logic up_fwd_o,
	output logic up_ignore_o,
	output logic up_prefetch_o
);

	bawd_state_t state_q;
	bawd_state_t state_d;

	logic [BAWD_ADDR_W-1:0] dn_addr;
	logic [BAWD_ADDR_W-1:0] up_addr;
	logic dn_hi_zero;
	logic up_hi_zero;

	////////////////////////////////////////////////////////////////////////////////
	// short address format carries no upper half
	assign dn_addr = dn_req_is_64_i ? dn_req_addr_i : {32'h0000_0000, dn_req_addr_i[31:0]};
	assign up_addr = up_req_is_64_i ? up_req_addr_i : {32'h0000_0000, up_req_addr_i[31:0]};
	assign dn_hi_zero = (dn_addr[63:32] == 32'h0000_0000);
	assign up_hi_zero = (up_addr[63:32] == 32'h0000_0000);

	////////////////////////////////////////////////////////////////////////////////
	// window compares, one set per direction
	bawd_hit_if dn_mem ();
	bawd_hit_if dn_pf ();
	bawd_hit_if dn_io ();
	bawd_hit_if dn_leg ();
	bawd_hit_if up_mem ();
	bawd_hit_if up_pf ();
	bawd_hit_if up_io ();
	bawd_hit_if up_leg ();

	// non-prefetchable window on bits 31:20
	bawd_range_cmp #(.W(BAWD_MEM_W)) u_dn_mem (
		.base_i(mem_base_i),
		.limit_i(mem_limit_i),
		.addr_i(dn_addr[31:BAWD_MEM_SHIFT]),
		.win(dn_mem)
	);
	bawd_range_cmp #(.W(BAWD_MEM_W)) u_up_mem (
		.base_i(mem_base_i),
		.limit_i(mem_limit_i),
		.addr_i(up_addr[31:BAWD_MEM_SHIFT]),
		.win(up_mem)
	);
	// prefetchable window on bits 63:20
	bawd_range_cmp #(.W(BAWD_PF_W)) u_dn_pf (
		.base_i(pf_base_i),
		.limit_i(pf_limit_i),
		.addr_i(dn_addr[63:BAWD_MEM_SHIFT]),
		.win(dn_pf)
	);
	bawd_range_cmp #(.W(BAWD_PF_W)) u_up_pf (
		.base_i(pf_base_i),
		.limit_i(pf_limit_i),
		.addr_i(up_addr[63:BAWD_MEM_SHIFT]),
		.win(up_pf)
	);
	// i/o window on bits 31:12
	bawd_range_cmp #(.W(BAWD_IO_W)) u_dn_io (
		.base_i(io_base_i),
		.limit_i(io_limit_i),
		.addr_i(dn_addr[31:BAWD_IO_SHIFT]),
		.win(dn_io)
	);
	bawd_range_cmp #(.W(BAWD_IO_W)) u_up_io (
		.base_i(io_base_i),
		.limit_i(io_limit_i),
		.addr_i(up_addr[31:BAWD_IO_SHIFT]),
		.win(up_io)
	);
	// legacy decoders
	bawd_legacy_dec u_dn_leg (
		.addr_i(dn_addr[31:0]),
		.hi_zero_i(dn_hi_zero),
		.is_io_i(dn_req_is_io_i),
		.vga_16bit_enable_i(vga_16bit_enable_i),
		.leg(dn_leg)
	);
	bawd_legacy_dec u_up_leg (
		.addr_i(up_addr[31:0]),
		.hi_zero_i(up_hi_zero),
		.is_io_i(up_req_is_io_i),
		.vga_16bit_enable_i(vga_16bit_enable_i),
		.leg(up_leg)
	);

	////////////////////////////////////////////////////////////////////////////////
	// claim terms per direction
	logic dn_mem_claim;
	logic dn_io_claim;
	logic up_mem_local;
	logic up_io_local;
	logic up_is_read;
	logic up_line_read;

	// non-prefetchable window is 32-bit only
	assign dn_mem_claim = (dn_mem.hit && dn_hi_zero) || dn_pf.hit
		|| (vga_enable_i && dn_leg.vga_hit);
	// isa hole carves the i/o window inside first 64 KB
	assign dn_io_claim = (dn_io.hit && dn_hi_zero && !(isa_enable_i && dn_leg.isa_hole))
		|| (vga_enable_i && dn_leg.vga_hit);
	assign up_mem_local = (up_mem.hit && up_hi_zero) || up_pf.hit
		|| (vga_enable_i && up_leg.vga_hit);
	assign up_io_local = (up_io.hit && up_hi_zero && !(isa_enable_i && up_leg.isa_hole))
		|| (vga_enable_i && up_leg.vga_hit);

	assign up_is_read = (up_req_cmd_i == BAWD_CMD_MEM_READ) || up_line_read;
	assign up_line_read = (up_req_cmd_i == BAWD_CMD_MEM_READ_LINE)
		|| (up_req_cmd_i == BAWD_CMD_MEM_READ_MULT);

	////////////////////////////////////////////////////////////////////////////////
	// next decision
	always_comb begin
		state_d = state_q;
		state_d.dn_valid = dn_req_valid_i;
		state_d.up_valid = up_req_valid_i;
		if (dn_req_valid_i) begin
			if (dn_req_is_io_i) begin
				state_d.dn_fwd = io_space_enable_i && dn_io_claim;
			end else begin
				state_d.dn_fwd = memory_space_enable_i && dn_mem_claim;
			end
			// unclaimed or disabled space completes as unsupported
			state_d.dn_ur = !state_d.dn_fwd;
			// downstream read takes exactly the requested count
			state_d.dn_bytes = (state_d.dn_fwd && dn_req_is_read_i && !dn_req_is_io_i)
				? dn_req_byte_count_i : '0;
		end else begin
			state_d.dn_fwd = 1'b0;
			state_d.dn_ur = 1'b0;
			state_d.dn_bytes = '0;
		end
		if (up_req_valid_i) begin
			// no bus mastering means the transaction is not claimed at all
			state_d.up_ignore = !bus_master_enable_i;
			if (up_req_is_io_i) begin
				state_d.up_fwd = bus_master_enable_i
					&& (!io_space_enable_i || !up_io_local);
			end else begin
				state_d.up_fwd = bus_master_enable_i
					&& (!memory_space_enable_i || !up_mem_local);
			end
			if (up_req_is_io_i || !state_d.up_fwd) begin
				state_d.up_prefetch = 1'b0;
			end else if (upstream_prefetchable_i) begin
				state_d.up_prefetch = up_is_read;
			end else begin
				state_d.up_prefetch = up_line_read;
			end
		end else begin
			state_d.up_ignore = 1'b0;
			state_d.up_fwd = 1'b0;
			state_d.up_prefetch = 1'b0;
		end
	end

	// result registers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= BAWD_STATE_RST;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign dn_rsp_valid_o = state_q.dn_valid;
	assign dn_fwd_o = state_q.dn_fwd;
	assign dn_ur_o = state_q.dn_ur;
	assign dn_read_bytes_o = state_q.dn_bytes;
	assign up_rsp_valid_o = state_q.up_valid;
	assign up_fwd_o = state_q.up_fwd;
	assign up_ignore_o = state_q.up_ignore;
	assign up_prefetch_o = state_q.up_prefetch;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_dn_mem_fwd: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && memory_space_enable_i && dn_hi_zero
		&& (mem_base_i <= mem_limit_i) && (dn_addr[31:20] >= mem_base_i)
		&& (dn_addr[31:20] <= mem_limit_i) |=> dn_rsp_valid_o && dn_fwd_o && !dn_ur_o)
		else $error("memory hit not forwarded downstream");

	a_up_np_local: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && !up_req_is_io_i && memory_space_enable_i && up_mem.hit
		&& up_hi_zero |=> up_rsp_valid_o && !up_fwd_o)
		else $error("window hit sent upstream");

	a_up_miss_fwd: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && !up_req_is_io_i && bus_master_enable_i && !up_mem.hit
		&& !up_pf.hit && !vga_enable_i |=> up_fwd_o)
		else $error("memory miss not sent upstream");

	a_mse_off_ur: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && !memory_space_enable_i
		|=> dn_ur_o && !dn_fwd_o && (dn_read_bytes_o == '0))
		else $error("memory request not unsupported");

	a_mse_off_up: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && !up_req_is_io_i && !memory_space_enable_i && bus_master_enable_i
		|=> up_fwd_o && !up_ignore_o)
		else $error("memory not sent upstream with space off");

	a_bme_off: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && !bus_master_enable_i |=> up_ignore_o && !up_fwd_o
		&& !up_prefetch_o)
		else $error("transaction taken without bus mastering");

	a_mem_granule: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && memory_space_enable_i && !dn_req_is_64_i
		&& (mem_base_i <= mem_limit_i) && (dn_req_addr_i[31:20] == mem_limit_i)
		|=> dn_fwd_o)
		else $error("last megabyte of window not claimed");

	a_pf_granule: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && memory_space_enable_i && dn_req_is_64_i
		&& (pf_base_i <= pf_limit_i) && (dn_req_addr_i[63:20] == pf_base_i)
		|=> dn_fwd_o)
		else $error("prefetchable granule not claimed");

	a_pf_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && (pf_base_i > pf_limit_i) && !vga_enable_i
		&& !(dn_mem.hit && dn_hi_zero) |=> !dn_fwd_o && dn_ur_o)
		else $error("disabled prefetchable window claimed");

	a_up_pf_local: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && !up_req_is_io_i && memory_space_enable_i && up_pf.hit
		|=> !up_fwd_o)
		else $error("prefetchable hit sent upstream");

	a_np_plain_read: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && (up_req_cmd_i == BAWD_CMD_MEM_READ) && !upstream_prefetchable_i
		|=> !up_prefetch_o)
		else $error("plain read prefetched in non-prefetchable space");

	a_pf_reads: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && !up_req_is_io_i && up_is_read
		&& (upstream_prefetchable_i || up_line_read)
		|=> up_prefetch_o == up_fwd_o)
		else $error("read prefetch policy wrong");

	a_dn_bytes: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && dn_req_is_read_i && !dn_req_is_io_i
		|=> dn_read_bytes_o == (dn_fwd_o ? $past(dn_req_byte_count_i) : '0))
		else $error("downstream read count altered");

	a_short_addr: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && !dn_req_is_64_i && !vga_enable_i
		&& (pf_base_i[BAWD_PF_W-1:12] != '0) && !dn_mem.hit |=> !dn_fwd_o)
		else $error("short address reached above 4 GB");

	a_io_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && dn_req_is_io_i && (io_base_i > io_limit_i) && !vga_enable_i
		|=> !dn_fwd_o && dn_ur_o)
		else $error("disabled i/o window claimed");

	// each direction on its own, requests on the two sides need not coincide
	a_io_off_dn: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && dn_req_is_io_i && !io_space_enable_i
		|=> dn_ur_o && !dn_fwd_o)
		else $error("i/o request not unsupported with space off");

	a_io_off_up: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && up_req_is_io_i && !io_space_enable_i && bus_master_enable_i
		|=> up_fwd_o)
		else $error("i/o not sent upstream with space off");

	a_isa_hole: assert property (@(posedge clk_i) disable iff (reset_i)
		up_req_valid_i && up_req_is_io_i && isa_enable_i && bus_master_enable_i
		&& up_hi_zero && (up_addr[31:16] == 16'h0000) && (up_addr[9:8] != 2'b00)
		&& !(vga_enable_i && up_leg.vga_hit) |=> up_fwd_o)
		else $error("isa alias not sent upstream");

	a_vga_claim: assert property (@(posedge clk_i) disable iff (reset_i)
		dn_req_valid_i && !dn_req_is_io_i && vga_enable_i && memory_space_enable_i
		&& dn_hi_zero && (dn_addr[31:0] >= BAWD_VGA_MEM_LO)
		&& (dn_addr[31:0] <= BAWD_VGA_MEM_HI) |=> dn_fwd_o)
		else $error("vga frame buffer not claimed");

endmodule

// File: pkg/bawd_pkg.sv
// Notes on behaviour
// - PCIe memory inside non-prefetchable window goes down
// - PCI memory outside both windows and any claimed VGA range goes up
// - memory enable clear: UR downstream, all up
// - bus master clear: PCI memory ignored
// - non-prefetchable window uses 1 MB granules
// - 64-bit prefetchable window uses 1 MB granules
// - prefetchable base above limit disables window
// - prefetchable hits go down, stay local upstream
// - non-prefetchable upstream: prefetch line/multiple reads only
// - prefetchable upstream: prefetch every memory read
// - downstream read uses exact requested byte count
// - short-address requests never reach above 4 GB
// - I/O base above limit disables I/O window
// - I/O enable clear: UR downstream, all up
// - I/O window decode, 4 KB granules
// - bus master clear: PCI I/O ignored
// - ISA enable splits each 1 KB block within first 64 KB
// - VGA enable claims legacy memory and I/O
package bawd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// address geometry
	localparam int BAWD_ADDR_W = 64;
	localparam int BAWD_MEM_SHIFT = 20; // 1 MB granule
	localparam int BAWD_IO_SHIFT = 12; // 4 KB granule
	localparam int BAWD_MEM_W = 32 - BAWD_MEM_SHIFT;
	localparam int BAWD_PF_W = BAWD_ADDR_W - BAWD_MEM_SHIFT;
	localparam int BAWD_IO_W = 32 - BAWD_IO_SHIFT;
	localparam int BAWD_BCNT_W = 13;

	////////////////////////////////////////////////////////////////////////////////
	// legacy ranges
	localparam logic [31:0] BAWD_VGA_MEM_LO = 32'h000A_0000;
	localparam logic [31:0] BAWD_VGA_MEM_HI = 32'h000B_FFFF;
	localparam logic [9:0] BAWD_VGA_IO_A_LO = 10'h3B0;
	localparam logic [9:0] BAWD_VGA_IO_A_HI = 10'h3BB;
	localparam logic [9:0] BAWD_VGA_IO_B_LO = 10'h3C0;
	localparam logic [9:0] BAWD_VGA_IO_B_HI = 10'h3DF;
	localparam logic [15:0] BAWD_ISA_TOP = 16'hFFFF; // end of first 64 KB

	////////////////////////////////////////////////////////////////////////////////
	// bus commands
	localparam logic [3:0] BAWD_CMD_MEM_READ = 4'h6;
	localparam logic [3:0] BAWD_CMD_MEM_READ_MULT = 4'hC;
	localparam logic [3:0] BAWD_CMD_MEM_READ_LINE = 4'hE;

	////////////////////////////////////////////////////////////////////////////////
	// registered decode results
	typedef struct packed {
		logic dn_valid;
		logic dn_fwd;
		logic dn_ur;
		logic [BAWD_BCNT_W-1:0] dn_bytes;
		logic up_valid;
		logic up_fwd;
		logic up_ignore;
		logic up_prefetch;
	} bawd_state_t;

	localparam bawd_state_t BAWD_STATE_RST = '0;

endpackage

// File: pkg/bawd_hit_if.sv
// carries one window or legacy decode toward the decision logic
interface bawd_hit_if;
	logic hit;
	logic enabled;
	logic vga_hit;
	logic isa_hole;
	modport range_src (output hit, output enabled);
	modport legacy_src (output vga_hit, output isa_hole);
	modport sink (input hit, input enabled, input vga_hit, input isa_hole);
endinterface

// File: design/bawd_range_cmp.sv
// inclusive base/limit compare on granule-aligned address bits
module bawd_range_cmp import bawd_pkg::*; #(
	parameter int W = 12
) (
	input wire logic [W-1:0] base_i,
	input wire logic [W-1:0] limit_i,
	input wire logic [W-1:0] addr_i,
	bawd_hit_if.range_src win
);

	// window live only while base not above limit
	assign win.enabled = (base_i <= limit_i);
	// limit covers its whole last granule
	assign win.hit = win.enabled && (addr_i >= base_i) && (addr_i <= limit_i);

endmodule

// File: design/bawd_legacy_dec.sv
// vga and isa legacy address recognition
module bawd_legacy_dec import bawd_pkg::*; (
	input wire logic [31:0] addr_i,
	input wire logic hi_zero_i,
	input wire logic is_io_i,
	input wire logic vga_16bit_enable_i,
	bawd_hit_if.legacy_src leg
);

	logic io_alias_ok;
	logic vga_io;
	logic vga_mem;

	// vga register ranges, bits 15:10 checked only in 16-bit mode
	assign io_alias_ok = !vga_16bit_enable_i || (addr_i[15:10] == 6'h00);
	assign vga_io = hi_zero_i && (addr_i[31:16] == 16'h0000) && io_alias_ok
		&& (((addr_i[9:0] >= BAWD_VGA_IO_A_LO) && (addr_i[9:0] <= BAWD_VGA_IO_A_HI))
		|| ((addr_i[9:0] >= BAWD_VGA_IO_B_LO) && (addr_i[9:0] <= BAWD_VGA_IO_B_HI)));
	// vga frame buffer
	assign vga_mem = hi_zero_i && (addr_i >= BAWD_VGA_MEM_LO) && (addr_i <= BAWD_VGA_MEM_HI);
	assign leg.vga_hit = is_io_i ? vga_io : vga_mem;

	// top 768 bytes of each 1 KB block within first 64 KB
	assign leg.isa_hole = is_io_i && hi_zero_i && (addr_i[31:16] == 16'h0000)
		&& (addr_i[15:0] <= BAWD_ISA_TOP) && (addr_i[9:8] != 2'b00);

endmodule

// File: bench/bawd_far_end.sv
// model of the link root port and the bus agents facing the decoder
module bawd_far_end import bawd_pkg::*; (
	input wire logic clk_i,
	output logic dn_valid_o,
	output logic dn_io_o,
	output logic dn_64_o,
	output logic dn_rd_o,
	output logic [BAWD_ADDR_W-1:0] dn_addr_o,
	output logic [BAWD_BCNT_W-1:0] dn_cnt_o,
	output logic up_valid_o,
	output logic up_io_o,
	output logic up_64_o,
	output logic [3:0] up_cmd_o,
	output logic [BAWD_ADDR_W-1:0] up_addr_o,
	input wire logic dn_rsp_i,
	input wire logic dn_fwd_i,
	input wire logic dn_ur_i,
	input wire logic [BAWD_BCNT_W-1:0] dn_bytes_i,
	input wire logic up_rsp_i,
	input wire logic up_fwd_i,
	input wire logic up_ign_i,
	input wire logic up_pf_i
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// idle levels at time zero
	initial begin
		{dn_valid_o, dn_io_o, dn_64_o, dn_rd_o, dn_addr_o, dn_cnt_o} = '0;
		{up_valid_o, up_io_o, up_64_o, up_cmd_o, up_addr_o} = '0;
	end

	// one link request; fields turn to their inverse once taken
	task automatic dn_send(input logic io, w64, rd, input logic [63:0] a,
			input logic [12:0] c, output logic [15:0] r);
		@(negedge clk_i);
		{dn_valid_o, dn_io_o, dn_64_o, dn_rd_o, dn_addr_o, dn_cnt_o} = {1'h1, io, w64, rd, a, c};
		@(negedge clk_i);
		r = {dn_rsp_i, dn_fwd_i, dn_ur_i, dn_bytes_i};
		{dn_valid_o, dn_io_o, dn_64_o, dn_rd_o, dn_addr_o, dn_cnt_o} = {1'h0, ~io, ~w64, ~rd, ~a, ~c};
	endtask

	// one bus transaction seen by the bridge
	task automatic up_send(input logic io, w64, input logic [3:0] cmd,
			input logic [63:0] a, output logic [3:0] r);
		@(negedge clk_i);
		{up_valid_o, up_io_o, up_64_o, up_cmd_o, up_addr_o} = {1'h1, io, w64, cmd, a};
		@(negedge clk_i);
		r = {up_rsp_i, up_fwd_i, up_ign_i, up_pf_i};
		{up_valid_o, up_io_o, up_64_o, up_cmd_o, up_addr_o} = {1'h0, ~io, ~w64, ~cmd, ~a};
	endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the window decoder
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bawd_pkg::*;

	localparam logic Y = 1'h1;
	localparam logic N = 1'h0;
	localparam logic [12:0] Z = 13'h0000;
	localparam logic [3:0] RD = BAWD_CMD_MEM_READ;
	localparam logic [3:0] WR = 4'h7;
	localparam logic [3:0] IOR = 4'h2;

	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic mem_en = 1'h1, io_en = 1'h1, master_en = 1'h1, isa = 1'h0;
	logic vga = 1'h0, vga16 = 1'h0, upf = 1'h0;
	logic [BAWD_MEM_W-1:0] mb = 12'h100, ml = 12'h1FF;
	logic [BAWD_PF_W-1:0] pb = 44'h000_0000_0F80, pl = 44'h000_0000_1007;
	logic [BAWD_IO_W-1:0] ib = 20'h00002, il = 20'h00003;
	logic dv, dio, d64, drd, uv, uio, u64, drv, dfw, dur, urv, ufw, uig, upe;
	logic [BAWD_ADDR_W-1:0] da, ua;
	logic [BAWD_BCNT_W-1:0] dc, dby;
	logic [3:0] ucmd;
	logic [3:0] cmds [3] = '{BAWD_CMD_MEM_READ, BAWD_CMD_MEM_READ_LINE, BAWD_CMD_MEM_READ_MULT};
	int n_mismatch = 0;
	int n_tests = 0;

	always #5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	// design and far side
	bawd_top DUT (.clk_i(clk_i), .reset_i(reset_i), .memory_space_enable_i(mem_en),
		.io_space_enable_i(io_en), .bus_master_enable_i(master_en), .isa_enable_i(isa),
		.vga_enable_i(vga), .vga_16bit_enable_i(vga16), .upstream_prefetchable_i(upf),
		.mem_base_i(mb), .mem_limit_i(ml), .pf_base_i(pb), .pf_limit_i(pl),
		.io_base_i(ib), .io_limit_i(il), .dn_req_valid_i(dv), .dn_req_is_io_i(dio),
		.dn_req_is_64_i(d64), .dn_req_is_read_i(drd), .dn_req_addr_i(da),
		.dn_req_byte_count_i(dc), .up_req_valid_i(uv), .up_req_is_io_i(uio),
		.up_req_is_64_i(u64), .up_req_cmd_i(ucmd), .up_req_addr_i(ua),
		.dn_rsp_valid_o(drv), .dn_fwd_o(dfw), .dn_ur_o(dur), .dn_read_bytes_o(dby),
		.up_rsp_valid_o(urv), .up_fwd_o(ufw), .up_ignore_o(uig), .up_prefetch_o(upe));

	bawd_far_end far (.clk_i(clk_i), .dn_valid_o(dv), .dn_io_o(dio), .dn_64_o(d64),
		.dn_rd_o(drd), .dn_addr_o(da), .dn_cnt_o(dc), .up_valid_o(uv), .up_io_o(uio),
		.up_64_o(u64), .up_cmd_o(ucmd), .up_addr_o(ua), .dn_rsp_i(drv), .dn_fwd_i(dfw),
		.dn_ur_i(dur), .dn_bytes_i(dby), .up_rsp_i(urv), .up_fwd_i(ufw), .up_ign_i(uig),
		.up_pf_i(upe));

	////////////////////////////////////////////////////////////////////////////////
	// compare, request and closing tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic dn_chk(input logic io, w64, rd, input logic [63:0] a,
			input logic [12:0] c, input logic ef, input logic [12:0] eb);
		logic [15:0] r;
		far.dn_send(io, w64, rd, a, c, r);
		check(r, {1'h1, ef, ~ef, eb});
	endtask

	task automatic up_chk(input logic io, w64, input logic [3:0] cmd,
			input logic [63:0] a, input logic ef, ei, ep);
		logic [3:0] r;
		far.up_send(io, w64, cmd, a, r);
		check({12'h000, r}, {12'h000, 1'h1, ef, ei, ep});
	endtask

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard, far beyond the hundred or so cycles of traffic
	initial begin
		#200000;
		n_mismatch++;
		end_sim;
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(negedge clk_i);
		reset_i = 1'h0;
		dn_chk(N, N, Y, 64'h1000_0000, 13'h01A4, Y, 13'h01A4);
		dn_chk(N, N, N, 64'h1FFF_FFFF, 13'h0004, Y, Z);
		dn_chk(N, N, Y, 64'h2000_0000, 13'h0010, N, Z);
		dn_chk(N, N, Y, 64'h0FFF_FFFF, 13'h0010, N, Z);
		dn_chk(N, N, Y, 64'hF800_0000, 13'h1FFF, Y, 13'h1FFF);
		dn_chk(N, Y, N, 64'h0_F800_0000, 13'h0004, Y, Z);
		dn_chk(N, Y, Y, 64'h1_0000_0000, 13'h0040, Y, 13'h0040);
		dn_chk(N, N, Y, 64'h1_0000_0000, 13'h0040, N, Z);
		dn_chk(N, Y, N, 64'h1_007F_FFFF, 13'h0004, Y, Z);
		dn_chk(N, Y, N, 64'h1_0080_0000, 13'h0004, N, Z);
		dn_chk(N, Y, N, 64'h1_1000_0000, 13'h0004, N, Z);
		for (int k = 0; k < 3; k++)
			up_chk(N, N, cmds[k], 64'h3000_0000, Y, N, cmds[k] != RD);
		up_chk(N, N, WR, 64'h3000_0000, Y, N, N);
		up_chk(N, N, RD, 64'h1000_0000, N, N, N);
		up_chk(N, N, RD, 64'hF800_0000, N, N, N);
		up_chk(N, Y, RD, 64'h1_0000_0000, N, N, N);
		upf = 1'h1;
		for (int k = 0; k < 3; k++)
			up_chk(N, N, cmds[k], 64'h3000_0000, Y, N, Y);
		// prefetchable base raised above limit in its upper half only
		pb = 44'h001_0000_0F80;
		dn_chk(N, N, Y, 64'hF800_0000, 13'h0008, N, Z);
		up_chk(N, N, RD, 64'hF800_0000, Y, N, Y);
		dn_chk(N, N, Y, 64'h1000_0000, 13'h0008, Y, 13'h0008);
		pb = 44'h000_0000_0F80;
		mem_en = 1'h0;
		dn_chk(N, N, Y, 64'h1000_0000, 13'h0008, N, Z);
		up_chk(N, N, WR, 64'h1000_0000, Y, N, N);
		mem_en = 1'h1;
		master_en = 1'h0;
		up_chk(N, N, RD, 64'h3000_0000, N, Y, N);
		up_chk(Y, N, IOR, 64'h5000, N, Y, N);
		master_en = 1'h1;
		dn_chk(Y, N, N, 64'h2000, 13'h0004, Y, Z);
		dn_chk(Y, N, N, 64'h3FFF, 13'h0004, Y, Z);
		dn_chk(Y, N, N, 64'h4000, 13'h0004, N, Z);
		dn_chk(Y, N, N, 64'h1FFF, 13'h0004, N, Z);
		up_chk(Y, N, IOR, 64'h2000, N, N, N);
		up_chk(Y, N, IOR, 64'h5000, Y, N, N);
		isa = 1'h1;
		dn_chk(Y, N, N, 64'h2100, 13'h0004, N, Z);
		dn_chk(Y, N, N, 64'h24FF, 13'h0004, Y, Z);
		up_chk(Y, N, IOR, 64'h2100, Y, N, N);
		isa = 1'h0;
		io_en = 1'h0;
		dn_chk(Y, N, N, 64'h2000, 13'h0004, N, Z);
		up_chk(Y, N, IOR, 64'h2000, Y, N, N);
		io_en = 1'h1;
		ib = 20'h10002;
		dn_chk(Y, N, N, 64'h2000, 13'h0004, N, Z);
		up_chk(Y, N, IOR, 64'h3000, Y, N, N);
		ib = 20'h00002;
		vga = 1'h1;
		dn_chk(N, N, Y, 64'hA_0000, 13'h0008, Y, 13'h0008);
		up_chk(N, N, RD, 64'hB_FFFF, N, N, N);
		dn_chk(Y, N, N, 64'h3C0, 13'h0004, Y, Z);
		up_chk(Y, N, IOR, 64'h3B0, N, N, N);
		dn_chk(Y, N, N, 64'h7C0, 13'h0004, Y, Z);
		vga16 = 1'h1;
		dn_chk(Y, N, N, 64'h7C0, 13'h0004, N, Z);
		vga = 1'h0;
		dn_chk(N, N, Y, 64'hA_0000, 13'h0008, N, Z);
		// answers stand one cycle only, then fall back to zero
		@(negedge clk_i);
		check({drv, dfw, dur, dby}, 16'h0000);
		check({12'h000, urv, ufw, uig, upe}, 16'h0000);
		end_sim;
	end
endmodule
